// File: hdl/alr_consts.vh
`ifndef ALR_CONSTS_VH
`define ALR_CONSTS_VH
// Register offsets of the plain register port
`define ALR_ADDR_W 4
`define ALR_OFS_ADV 4'h0
`define ALR_OFS_PARTNER 4'h1
`define ALR_OFS_RESULT 4'h2
`define ALR_OFS_CTRL 4'h3
`define ALR_OFS_IRQ_STAT 4'h4
`define ALR_OFS_IRQ_MASK 4'h5
// Advertisement register fields
`define ALR_ADV_LEADER 0
`define ALR_ADV_FORCED 1
`define ALR_ADV_HI_ABLE 2
`define ALR_ADV_HI_REQ 3
`define ALR_ADV_LOCAL_CAP 4
// Result register fields
`define ALR_RES_ROLE_LSB 0
`define ALR_RES_ROLE_MSB 1
`define ALR_RES_AMP 2
`define ALR_RES_DONE 3
`define ALR_RES_FAIL 4
`define ALR_RES_LINK 5
// Role result codes
`define ALR_ROLE_NONE 2'h0
`define ALR_ROLE_LEADER 2'h1
`define ALR_ROLE_FOLLOWER 2'h2
`define ALR_ROLE_FAULT 2'h3
// Control register fields
`define ALR_CTRL_RESTART 0
`define ALR_CTRL_SWRESET 1
// Interrupt bits
`define ALR_IRQ_DONE 0
`define ALR_IRQ_FAULT 1
`define ALR_IRQ_W 2
// LFSR seed and taps
`define ALR_LFSR_SEED 16'hace1
`define ALR_LFSR_TAPS 16'hb400
`endif

// File: hdl/alr_role_resolution.v
`timescale 1ns/1ns
`include "alr_consts.vh"

module alr_role_resolution #(
    parameter LFSR_W = 16
) (
    input wire ref_clk, // System clock
    input wire rst_b, // Asynchronous reset, active low
    input wire high_amplitude_strap, // Strap enabling 2.4V mode
    input wire role_pref_strap, // Strap for leader preference
    input wire [`ALR_ADDR_W-1:0] regAddr, // Register address
    input wire [15:0] regWrData, // Register write data
    input wire regWrStb, // Register write strobe
    input wire regRdStb, // Register read strobe
    input wire partnerValid, // Partner page received, one-cycle pulse
    input wire partner_high_level_ability, // Partner ability bit
    input wire partner_high_level_request, // Partner request bit
    input wire partner_role_forced, // Partner forced role bit
    input wire partner_leader_pref, // Partner leader preference bit
    input wire pageFail, // Other negotiation failure, pulse
    input wire linkDrop, // Link lost, pulse
    output reg [15:0] regRdData, // Read data, cycle after strobe
    output reg amplitude_select, // 1 selects 2.4V transmit level
    output reg [1:0] role_resolution_result, // Role result code
    output reg negotiation_done, // Negotiation complete flag
    output reg linkUp, // Link allowed up
    output reg restartReq, // Restart pulse to page exchange
    output reg irqOut // Level interrupt
);
    // ----------------------------------------------------------
    // Registers
    // ----------------------------------------------------------
    reg adv_leader_pref_reg;
    reg adv_role_forced_reg;
    reg adv_high_level_ability_reg;
    reg adv_high_level_request_reg;
    reg capReg;
    reg strapSeenReg;
    reg [3:0] partnerReg;
    reg failReg;
    reg [`ALR_IRQ_W-1:0] irqStatReg;
    reg [`ALR_IRQ_W-1:0] irqMaskReg;
    reg [LFSR_W-1:0] lfsrReg;
    reg randBitReg;
    reg swResetReg;
    reg failSeenReg;

    wire local_high_level_capable;
    wire adv_ability_low_word_hi;
    reg [1:0] roleNext;
    reg ampNext;
    reg [15:0] rdNext;
    wire [`ALR_IRQ_W-1:0] irqEvent;
    wire ctrlWrite;
    wire maskWrite;
    wire statRead;
    wire roleFault;
    wire clearNeg;
    wire strapLoad;

    assign local_high_level_capable = capReg;

    // ----------------------------------------------------------
    // Functions
    // ----------------------------------------------------------
    // Role resolution per partner and local advertisement
    function [1:0] resolveRole;
        input lf;
        input lm;
        input rf;
        input rm;
        input rnd;
        begin
            if (lf && rf) begin
                if (lm == rm) begin
                    resolveRole = `ALR_ROLE_FAULT;
                end else begin
                    resolveRole = lm ? `ALR_ROLE_LEADER : `ALR_ROLE_FOLLOWER;
                end
            end else if (lf) begin
                resolveRole = lm ? `ALR_ROLE_LEADER : `ALR_ROLE_FOLLOWER;
            end else if (rf) begin
                resolveRole = rm ? `ALR_ROLE_FOLLOWER : `ALR_ROLE_LEADER;
            end else if (lm == rm) begin
                resolveRole = rnd ? `ALR_ROLE_LEADER : `ALR_ROLE_FOLLOWER;
            end else begin
                resolveRole = lm ? `ALR_ROLE_LEADER : `ALR_ROLE_FOLLOWER;
            end
        end
    endfunction

    // Transmit level: both able and any request gives 2.4V
    function ampResolve;
        input la;
        input lr;
        input ra;
        input rr;
        begin
            ampResolve = la & ra & (lr | rr);
        end
    endfunction

    // Strobe qualified by one register offset
    function addrHit;
        input stb;
        input [`ALR_ADDR_W-1:0] addr;
        input [`ALR_ADDR_W-1:0] ofs;
        begin
            addrHit = stb && (addr == ofs);
        end
    endfunction

    // ----------------------------------------------------------
    // Resolution logic
    // ----------------------------------------------------------
    // Combinational level and role from the local advertisement and the live partner lines
    always @* begin
        // Both able and any request gives 2.4V, else 1.0V
        ampNext = ampResolve(adv_high_level_ability_reg, adv_high_level_request_reg,
            partner_high_level_ability, partner_high_level_request);
        roleNext = resolveRole(adv_role_forced_reg, adv_leader_pref_reg,
            partner_role_forced, partner_leader_pref, randBitReg);
    end

    // Register strobes decoded once per offset
    assign ctrlWrite = addrHit(regWrStb, regAddr, `ALR_OFS_CTRL);
    assign maskWrite = addrHit(regWrStb, regAddr, `ALR_OFS_IRQ_MASK);
    assign statRead = addrHit(regRdStb, regAddr, `ALR_OFS_IRQ_STAT);
    assign adv_ability_low_word_hi = addrHit(regWrStb, regAddr, `ALR_OFS_ADV);

    // Fault code, clear condition and strap load shared by several flops
    assign roleFault = (roleNext == `ALR_ROLE_FAULT);
    assign clearNeg = !pageFail && (restartReq || linkDrop);
    assign strapLoad = !strapSeenReg || swResetReg;

    // Events that set the sticky status bits
    assign irqEvent[`ALR_IRQ_DONE] = partnerValid;
    assign irqEvent[`ALR_IRQ_FAULT] = partnerValid && roleFault;

    // ----------------------------------------------------------
    // Random source
    // ----------------------------------------------------------
    // Free-running LFSR, seeded away from the all-zero lock-up state
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lfsrReg <= `ALR_LFSR_SEED;
        end else begin
            lfsrReg <= {lfsrReg[LFSR_W-2:0], ^(lfsrReg & `ALR_LFSR_TAPS)};
        end
    end

    // One random bit taken per negotiation attempt
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            randBitReg <= 1'b0;
        end else if (restartReq) begin
            randBitReg <= lfsrReg[0];
        end
    end

    // ----------------------------------------------------------
    // Straps and advertisement
    // ----------------------------------------------------------
    // Strap capture flag and read-only capability bit
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strapSeenReg <= 1'b0;
            capReg <= 1'b0;
        end else if (strapLoad) begin
            strapSeenReg <= 1'b1;
            capReg <= high_amplitude_strap;
        end
    end

    // Advertisement bits, loaded from straps after any reset, except the forced bit, which is cleared
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            adv_leader_pref_reg <= 1'b0;
            adv_role_forced_reg <= 1'b0;
            adv_high_level_ability_reg <= 1'b0;
            adv_high_level_request_reg <= 1'b0;
        end else if (strapLoad) begin
            adv_leader_pref_reg <= role_pref_strap;
            adv_role_forced_reg <= 1'b0;
            adv_high_level_ability_reg <= high_amplitude_strap;
            adv_high_level_request_reg <= high_amplitude_strap;
        end else if (adv_ability_low_word_hi) begin
            adv_leader_pref_reg <= regWrData[`ALR_ADV_LEADER];
            adv_role_forced_reg <= regWrData[`ALR_ADV_FORCED];
            if (capReg) begin
                adv_high_level_ability_reg <= regWrData[`ALR_ADV_HI_ABLE];
                adv_high_level_request_reg <= regWrData[`ALR_ADV_HI_REQ];
            end
        end
    end

    // ----------------------------------------------------------
    // Negotiation control
    // ----------------------------------------------------------
    // Restart and software reset pulses from the control register
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            restartReq <= 1'b0;
            swResetReg <= 1'b0;
        end else begin
            restartReq <= ctrlWrite && (regWrData[`ALR_CTRL_RESTART] || regWrData[`ALR_CTRL_SWRESET]);
            swResetReg <= ctrlWrite && regWrData[`ALR_CTRL_SWRESET];
        end
    end

    // Partner page bits, kept until the next page
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            partnerReg <= 4'h0;
        end else if (partnerValid) begin
            partnerReg <= {partner_high_level_ability, partner_high_level_request,
                partner_role_forced, partner_leader_pref};
        end
    end

    // Completion flag, cleared by restart or link loss unless pageFail comes in the same cycle
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            negotiation_done <= 1'b0;
        end else if (partnerValid) begin
            negotiation_done <= 1'b1;
        end else if (clearNeg) begin
            negotiation_done <= 1'b0;
        end
    end

    // Role result code, valid while the completion flag is set
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            role_resolution_result <= `ALR_ROLE_NONE;
        end else if (partnerValid) begin
            role_resolution_result <= roleNext;
        end else if (clearNeg) begin
            role_resolution_result <= `ALR_ROLE_NONE;
        end
    end

    // Failure flag for a role fault or a failed page exchange
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            failReg <= 1'b0;
        end else if (partnerValid) begin
            failReg <= roleFault;
        end else if (pageFail) begin
            failReg <= 1'b1;
        end
    end

    // Failure memory; only a restart lets a later page bring the link up
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            failSeenReg <= 1'b0;
        end else if (restartReq) begin
            failSeenReg <= 1'b0;
        end else if (pageFail || (partnerValid && roleFault)) begin
            failSeenReg <= 1'b1;
        end
    end

    // Link stays down after a failure until a clean completion that follows a restart
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            linkUp <= 1'b0;
        end else if (partnerValid) begin
            linkUp <= !roleFault && !failSeenReg;
        end else if (pageFail || restartReq || linkDrop) begin
            linkUp <= 1'b0;
        end
    end

    // Transmit level, held until the next clean completion
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            amplitude_select <= 1'b0;
        end else if (partnerValid && !roleFault) begin
            amplitude_select <= capReg & ampNext;
        end
    end

    // ----------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------
    // Sticky status, set wins over read clear
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqStatReg <= {`ALR_IRQ_W{1'b0}};
        end else if (statRead) begin
            irqStatReg <= irqEvent;
        end else begin
            irqStatReg <= irqStatReg | irqEvent;
        end
    end

    // Mask register written by software
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqMaskReg <= {`ALR_IRQ_W{1'b0}};
        end else if (maskWrite) begin
            irqMaskReg <= regWrData[`ALR_IRQ_W-1:0];
        end
    end

    // Level output, dropping bits that a status read is clearing
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |(irqStatReg & irqMaskReg & {`ALR_IRQ_W{!statRead}}) | |(irqEvent & irqMaskReg);
        end
    end

    // ----------------------------------------------------------
    // Register read
    // ----------------------------------------------------------
    // Read mux by address
    always @* begin
        rdNext = 16'h0000;
        if (regAddr == `ALR_OFS_ADV) begin
            rdNext[`ALR_ADV_LEADER] = adv_leader_pref_reg;
            rdNext[`ALR_ADV_FORCED] = adv_role_forced_reg;
            rdNext[`ALR_ADV_HI_ABLE] = adv_high_level_ability_reg;
            rdNext[`ALR_ADV_HI_REQ] = adv_high_level_request_reg;
            rdNext[`ALR_ADV_LOCAL_CAP] = local_high_level_capable;
        end else if (regAddr == `ALR_OFS_PARTNER) begin
            rdNext[3:0] = partnerReg;
        end else if (regAddr == `ALR_OFS_RESULT) begin
            rdNext[`ALR_RES_ROLE_MSB:`ALR_RES_ROLE_LSB] = role_resolution_result;
            rdNext[`ALR_RES_AMP] = amplitude_select;
            rdNext[`ALR_RES_DONE] = negotiation_done;
            rdNext[`ALR_RES_FAIL] = failReg;
            rdNext[`ALR_RES_LINK] = linkUp;
        end else if (regAddr == `ALR_OFS_IRQ_STAT) begin
            rdNext[`ALR_IRQ_W-1:0] = irqStatReg;
        end else if (regAddr == `ALR_OFS_IRQ_MASK) begin
            rdNext[`ALR_IRQ_W-1:0] = irqMaskReg;
        end
    end

    // Read data valid only the cycle after the strobe
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 16'h0000;
        end else if (regRdStb) begin
            regRdData <= rdNext;
        end else begin
            regRdData <= 16'h0000;
        end
    end
endmodule // alr_role_resolution

// File: tb/alr_role_resolution_assertions.sv
`timescale 1ns/1ns
`include "alr_consts.vh"
// ----------------------------------------
// Port checker for the resolution block
// ----------------------------------------
module alr_role_resolution_assertions (
    input wire ref_clk, // System clock
    input wire rst_b, // Reset, active low
    input wire partnerValid, // Partner page pulse
    input wire partner_high_level_ability, // Partner ability bit
    input wire partner_role_forced, // Partner forced bit
    input wire partner_leader_pref, // Partner preference bit
    input wire amplitude_select, // Amplitude output
    input wire [1:0] role_resolution_result, // Role code
    input wire negotiation_done, // Done flag
    input wire linkUp, // Link state
    input wire restartReq // Restart pulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Short alias for the role code
    wire [1:0] res = role_resolution_result;
    // A page completes negotiation one cycle later
    done_on_page_a: assert property (partnerValid |=> negotiation_done)
        else $error("done flag missing after page");
    low_amp_a: assert property (partnerValid && !partner_high_level_ability |=> !amplitude_select)
        else $error("high amplitude without partner ability");
    amp_hold_a: assert property (!partnerValid |=> $stable(amplitude_select))
        else $error("amplitude changed without a page");
    forced_wins_a: assert property (partnerValid && partner_role_forced |=> res == `ALR_ROLE_FAULT ||
        res == ($past(partner_leader_pref) ? `ALR_ROLE_FOLLOWER : `ALR_ROLE_LEADER)) else $error("forced role lost");
    result_valid_a: assert property (negotiation_done |-> res != `ALR_ROLE_NONE)
        else $error("done without a role");
    fault_link_a: assert property (res == `ALR_ROLE_FAULT |-> !linkUp)
        else $error("link up on role fault");
    link_done_a: assert property (linkUp |-> negotiation_done)
        else $error("link up without negotiation");
    restart_clear_a: assert property (restartReq |=> !negotiation_done && !linkUp && res == `ALR_ROLE_NONE)
        else $error("restart left state behind");
    cover property (res == `ALR_ROLE_FAULT);
    cover property (amplitude_select && negotiation_done);
    cover property (partnerValid && partner_role_forced);
endmodule // alr_role_resolution_assertions

bind alr_role_resolution alr_role_resolution_assertions chk_u (.ref_clk, .rst_b, .partnerValid,
    .partner_high_level_ability, .partner_role_forced, .partner_leader_pref, .amplitude_select,
    .role_resolution_result, .negotiation_done, .linkUp, .restartReq);

// File: tb/alr_partner_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Far-side page source
// ----------------------------------------
module alr_partner_model (
    input wire ref_clk, // System clock
    output reg pageValid, // Page complete pulse
    output reg [3:0] pageBits // Ability, request, forced, leader
);
    // Lines idle with no page
    initial begin
        pageValid = 1'b0;
        pageBits = 4'h5;
    end
    // Sends one page after a wait, then lets the lines go stale
    task send(input [3:0] bits, input [1:0] gap);
        repeat (gap) @(posedge ref_clk);
        pageValid <= 1'b1;
        pageBits <= bits;
        @(posedge ref_clk);
        pageValid <= 1'b0;
        pageBits <= ~bits; // Stale lines show no real page
    endtask
endmodule // alr_partner_model

// File: tb/tb_alr_role_resolution.sv
`timescale 1ns/1ns
`include "alr_consts.vh"
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb_alr_role_resolution;
    reg ref_clk, rst_b, hiStrap, roleStrap, regWrStb, regRdStb, pageFail, linkDrop;
    reg [3:0] regAddr;
    reg [15:0] regWrData, got;
    reg [1:0] e;
    reg seenL, seenF;
    wire pValid, ampSel, negDone, linkUp, restartReq, irqOut;
    wire [3:0] pBits;
    wire [15:0] regRdData;
    wire [1:0] role;
    integer error_cnt = 0, compares = 0, cycles = 0, i;
    alr_partner_model partner_u (.ref_clk(ref_clk), .pageValid(pValid), .pageBits(pBits));
    alr_role_resolution dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .high_amplitude_strap(hiStrap),
        .role_pref_strap(roleStrap), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .partnerValid(pValid), .partner_high_level_ability(pBits[3]),
        .partner_high_level_request(pBits[2]), .partner_role_forced(pBits[1]), .partner_leader_pref(pBits[0]),
        .pageFail(pageFail), .linkDrop(linkDrop), .regRdData(regRdData), .amplitude_select(ampSel),
        .role_resolution_result(role), .negotiation_done(negDone), .linkUp(linkUp), .restartReq(restartReq),
        .irqOut(irqOut));
    task chk(input string what, input [15:0] seen, input [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge ref_clk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
    endtask
    task rd(input [3:0] a);
        @(posedge ref_clk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        #1 got = regRdData;
    endtask
    // Restart, let the partner answer, then fetch the result
    task neg(input [3:0] bits, input [1:0] gap);
        wr(`ALR_OFS_CTRL, 16'h0001);
        partner_u.send(bits, gap);
        rd(`ALR_OFS_RESULT);
    endtask
    // Role table: local forced, local leader, remote forced, remote leader
    function [1:0] expRole(input [3:0] k);
        if (k[3] & k[1])
            expRole = (k[2] == k[0]) ? `ALR_ROLE_FAULT : (k[2] ? `ALR_ROLE_LEADER : `ALR_ROLE_FOLLOWER);
        else if (k[1])
            expRole = k[0] ? `ALR_ROLE_FOLLOWER : `ALR_ROLE_LEADER;
        else if (k[3] | (k[2] != k[0]))
            expRole = k[2] ? `ALR_ROLE_LEADER : `ALR_ROLE_FOLLOWER;
        else
            expRole = `ALR_ROLE_NONE;
    endfunction
    task t_reset;
        rd(`ALR_OFS_ADV);
        chk("advReset", got & 16'h001f, 16'h001d);
        wr(`ALR_OFS_ADV, 16'h0002);
        rd(`ALR_OFS_ADV);
        chk("advWrite", got & 16'h001f, 16'h0012);
    endtask
    task t_amp;
        for (i = 0; i < 16; i = i + 1) begin
            wr(`ALR_OFS_ADV, {12'h000, i[3:2], 2'b01});
            neg({i[1:0], 2'b00}, 2'd1);
            chk("amp", {15'h0000, got[`ALR_RES_AMP]}, {15'h0000, i[2] & i[1] & (i[3] | i[0])});
            chk("ampPin", {15'h0000, ampSel}, {15'h0000, i[2] & i[1] & (i[3] | i[0])});
            chk("done", {15'h0000, got[`ALR_RES_DONE]}, 16'h0001);
            rd(`ALR_OFS_PARTNER);
            chk("partner", got & 16'h000f, {12'h000, i[1:0], 2'b00});
        end
    endtask
    task t_role;
        for (i = 0; i < 16; i = i + 1) begin
            wr(`ALR_OFS_ADV, {12'h000, 2'b00, i[3:2]});
            neg({2'b00, i[1:0]}, 2'd2);
            e = expRole(i[3:0]);
            if (e == `ALR_ROLE_NONE)
                chk("randRole", {15'h0000, role == `ALR_ROLE_LEADER || role == `ALR_ROLE_FOLLOWER}, 16'h0001);
            else
                chk("role", {14'h0000, role}, {14'h0000, e});
            chk("link", {15'h0000, linkUp}, {15'h0000, e != `ALR_ROLE_FAULT});
        end
        seenL = 1'b0;
        seenF = 1'b0;
        wr(`ALR_OFS_ADV, 16'h0001);
        for (i = 0; i < 12; i = i + 1) begin
            neg(4'h1, i % 3 + 1);
            seenL = seenL | (role === `ALR_ROLE_LEADER);
            seenF = seenF | (role === `ALR_ROLE_FOLLOWER);
        end
        chk("bothRoles", {14'h0000, seenL, seenF}, 16'h0003);
    endtask
    task t_strap;
        @(posedge ref_clk);
        hiStrap <= 1'b0;
        roleStrap <= 1'b0;
        wr(`ALR_OFS_CTRL, 16'h0002);
        rd(`ALR_OFS_ADV);
        chk("advStrap", got & 16'h001f, 16'h0000);
        wr(`ALR_OFS_ADV, 16'h000c);
        rd(`ALR_OFS_ADV);
        chk("advRefused", got & 16'h001f, 16'h0000);
        neg(4'hc, 2'd1);
        chk("ampLow", {15'h0000, ampSel}, 16'h0000);
    endtask
    task t_irq;
        rd(`ALR_OFS_IRQ_STAT);
        wr(`ALR_OFS_IRQ_MASK, 16'h0001);
        neg(4'h0, 2'd1);
        chk("irqOn", {15'h0000, irqOut}, 16'h0001);
        rd(`ALR_OFS_IRQ_STAT);
        chk("irqStat", got & 16'h0003, 16'h0001);
        repeat (2) @(posedge ref_clk);
        chk("irqOff", {15'h0000, irqOut}, 16'h0000);
        wr(`ALR_OFS_IRQ_MASK, 16'h0000);
        neg(4'h0, 2'd1);
        chk("irqMasked", {15'h0000, irqOut}, 16'h0000);
        @(posedge ref_clk);
        linkDrop <= 1'b1;
        @(posedge ref_clk);
        linkDrop <= 1'b0;
        rd(`ALR_OFS_IRQ_STAT);
        chk("linkDrop", {15'h0000, linkUp}, 16'h0000);
        @(posedge ref_clk);
        pageFail <= 1'b1;
        @(posedge ref_clk);
        pageFail <= 1'b0;
        rd(`ALR_OFS_RESULT);
        chk("pageFail", got & 16'h0030, 16'h0010);
        rd(4'hf);
        chk("unmapped", got, 16'h0000);
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            print_verdict;
        end
    end
    // Main sequence
    initial begin
        {rst_b, regWrStb, regRdStb, pageFail, linkDrop, regAddr, regWrData} = 0;
        hiStrap = 1'b1;
        roleStrap = 1'b1;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset;
        t_amp;
        t_role;
        t_strap;
        t_irq;
        print_verdict;
    end
endmodule // tb_alr_role_resolution
